// File: design/chan_cfg_pkg.sv
// Shared constants and types for the channel configuration block
package chan_cfg_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [6:0] ADDR_POWERDOWN  = 7'h02;
    localparam logic [6:0] ADDR_FEATURE    = 7'h03;
    localparam logic [7:0] POWERDOWN_RESET = 8'h00;
    localparam logic [7:0] FEATURE_RESET   = 8'h00;
    localparam logic [7:0] ALL_OFF         = 8'hff;
    localparam logic [7:0] ABSENT_MASK     = 8'hf0;
    localparam logic [7:0] NONE_MASK       = 8'h00;

    // ************************************************************
    // Serial frame layout
    // ************************************************************
    localparam int         CMD_BITS   = 16;
    localparam int         FRAME_BITS = 25;
    localparam int         ADDR_HI    = 15;
    localparam int         ADDR_LO    = 9;
    localparam int         WR_BIT     = 8;
    localparam int         DATA_HI    = 7;
    localparam logic [4:0] CMD_LAST   = 5'h0f;
    localparam logic [4:0] CMD_DONE   = 5'h10;
    localparam logic [16:0] READ_PAD  = 17'h00000;
    localparam logic [1:0]  RES_PAD   = 2'h0;
    localparam logic [8:0]  TAG_LOW   = 9'h000;
    localparam int         FIFO_DEPTH = 16;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [1:0] chain_device_id;
        logic       zero5;
        logic       alarm_en;
        logic       zero3;
        logic [2:0] output_frame_format;
    } feature_t;

    typedef struct packed {
        logic [3:0]  chan;
        logic [13:0] data;
    } result_word_t;

    typedef enum logic [2:0] {
        FMT_RESULT = 3'b000,
        FMT_CHAN   = 3'b001,
        FMT_DEV    = 3'b010,
        FMT_RANGE  = 3'b011
    } fmt_t;

    typedef enum logic [1:0] {
        FRAME_IDLE  = 2'b00,
        FRAME_CMD   = 2'b01,
        FRAME_LOAD  = 2'b10,
        FRAME_SHIFT = 2'b11
    } frame_state_t;

endpackage

// File: design/result_fifo.sv
// Synchronous FIFO holding conversion results
`timescale 1ns/100ps
module result_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    // ************************************************************
    // Pointers and flags
    // ************************************************************
    always_comb begin
        empty     = (wr_q == rd_q);
        full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
        in_ready  = !full;
        out_valid = !empty;
        push      = in_valid && !full;
        pop       = out_ready && !empty;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
        out_data  = mem_q[rd_q[AW-1:0]];
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    a_no_overflow : assert property (@(posedge mclk) disable iff (!nrst)
        full |=> (wr_q == $past(wr_q)))
        else $error("fifo written while full");

endmodule

// File: design/chan_cfg_top.sv
// Power-down and output-format registers with the serial result frame
`timescale 1ns/100ps
module chan_cfg_top #(
    parameter bit FOUR_CHAN = 1'b0
) (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire logic                        sclk,
    input  wire logic                        cs_n,
    input  wire logic                        sdi,
    output logic                             sdo,
    output logic                             sdo_oe_n,
    input  wire logic                        conv_valid,
    output logic                             conv_ready,
    input  wire chan_cfg_pkg::result_word_t  conv_data,
    input  wire logic [7:0][3:0]             chan_range,
    input  wire logic                        manual_channel_mode,
    input  wire logic [2:0]                  manual_channel_sel,
    output logic      [7:0]                  frontend_off,
    output logic      [7:0]                  scan_allowed,
    output logic                             alarm_enable,
    output logic                             result_invalid,
    output logic                             false_alarm_risk
);
    import chan_cfg_pkg::*;

    logic [2:0]   sclk_s;
    logic [1:0]   cs_s;
    logic [1:0]   sdi_s;
    logic         rise;
    logic         fall;

    frame_state_t state_q;
    frame_state_t state_d;
    logic [4:0]   cnt_q;
    logic [4:0]   cnt_d;
    logic [15:0]  cmd_q;
    logic [15:0]  cmd_d;
    logic [15:0]  cmd_word;
    logic [24:0]  out_q;
    logic [24:0]  out_d;
    logic         oe_n_q;
    logic         oe_n_d;
    logic         reply_q;
    logic         reply_d;
    logic [7:0]   rdata_q;
    logic [7:0]   rdata_d;
    logic [7:0]   pd_q;
    logic [7:0]   pd_d;
    feature_t     feat_q;
    feature_t     feat_d;
    result_word_t held_q;
    result_word_t held_d;
    result_word_t word;
    result_word_t fifo_data;
    logic         fifo_valid;
    logic         pop;
    logic [7:0]   absent;
    logic         load_result;
    logic         load_read;
    logic [6:0]   addr;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sclk_s <= '0;
            cs_s   <= 2'h3;
            sdi_s  <= '0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s   <= {cs_s[0], cs_n};
            sdi_s  <= {sdi_s[0], sdi};
        end
    end

    assign rise = sclk_s[1] && !sclk_s[2];
    assign fall = !sclk_s[1] && sclk_s[2];

    // ************************************************************
    // Result buffer
    // ************************************************************
    result_fifo #(
        .WIDTH ($bits(result_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .in_data   (conv_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    // ************************************************************
    // Frame assembly
    // ************************************************************
    function automatic logic [24:0] build_frame(
        input result_word_t w,
        input logic [2:0]   fmt,
        input logic [1:0]   dev,
        input logic [3:0]   rng
    );
        logic [24:0] f;
        f = {w.data, RES_PAD, TAG_LOW};
        case (fmt)
            FMT_CHAN: begin
                f[8:5] = w.chan;
            end
            FMT_DEV: begin
                f[8:5] = w.chan;
                f[4:3] = dev;
            end
            FMT_RANGE: begin
                f[8:5] = w.chan;
                f[4:3] = dev;
                f[2:0] = rng[2:0];
            end
            default: begin
                f[8:0] = TAG_LOW;
            end
        endcase
        return f;
    endfunction

    // ************************************************************
    // Frame control and registers
    // ************************************************************
    assign absent   = FOUR_CHAN ? ABSENT_MASK : NONE_MASK;
    assign cmd_word = {cmd_q[14:0], sdi_s[1]};
    assign addr     = cmd_word[ADDR_HI:ADDR_LO];

    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        cmd_d       = cmd_q;
        out_d       = out_q;
        oe_n_d      = oe_n_q;
        reply_d     = reply_q;
        rdata_d     = rdata_q;
        pd_d        = pd_q;
        feat_d      = feat_q;
        held_d      = held_q;
        pop         = 1'b0;
        load_result = 1'b0;
        load_read   = 1'b0;
        word        = fifo_valid ? fifo_data : held_q;
        if (cs_s[1]) begin
            state_d = FRAME_IDLE;
            cnt_d   = '0;
            oe_n_d  = 1'b1;
        end else begin
            case (state_q)
                FRAME_IDLE: begin
                    state_d = FRAME_CMD;
                    cnt_d   = '0;
                end
                FRAME_CMD: begin
                    if (rise) begin
                        cmd_d = cmd_word;
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == CMD_LAST) begin
                            state_d = FRAME_LOAD;
                            reply_d = 1'b0;
                            if (cmd_word[WR_BIT]) begin
                                if (addr == ADDR_POWERDOWN) begin
                                    pd_d = (cmd_word[DATA_HI:0] & ~absent)
                                        | (pd_q & absent);
                                end else if (addr == ADDR_FEATURE) begin
                                    feat_d       = cmd_word[DATA_HI:0];
                                    feat_d.zero5 = 1'b0;
                                    feat_d.zero3 = 1'b0;
                                end
                            end else if (addr == ADDR_POWERDOWN) begin
                                reply_d = 1'b1;
                                rdata_d = pd_q | absent;
                            end else if (addr == ADDR_FEATURE) begin
                                reply_d = 1'b1;
                                rdata_d = feat_q;
                            end
                        end
                    end
                end
                FRAME_LOAD: begin
                    if (fall) begin
                        state_d = FRAME_SHIFT;
                        oe_n_d  = 1'b0;
                        if (reply_q) begin
                            load_read = 1'b1;
                            out_d     = {rdata_q, READ_PAD};
                        end else begin
                            load_result = 1'b1;
                            pop         = fifo_valid;
                            held_d      = word;
                            out_d       = build_frame(word, feat_q.output_frame_format,
                                feat_q.chain_device_id, chan_range[word.chan[2:0]]);
                        end
                    end
                end
                FRAME_SHIFT: begin
                    if (fall) begin
                        out_d = {out_q[23:0], 1'b0};
                    end
                end
                default: begin
                    state_d = FRAME_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q <= FRAME_IDLE;
            cnt_q   <= '0;
            cmd_q   <= '0;
            out_q   <= '0;
            oe_n_q  <= 1'b1;
            reply_q <= 1'b0;
            rdata_q <= '0;
            pd_q    <= POWERDOWN_RESET;
            feat_q  <= FEATURE_RESET;
            held_q  <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cmd_q   <= cmd_d;
            out_q   <= out_d;
            oe_n_q  <= oe_n_d;
            reply_q <= reply_d;
            rdata_q <= rdata_d;
            pd_q    <= pd_d;
            feat_q  <= feat_d;
            held_q  <= held_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sdo              = out_q[FRAME_BITS-1];
    assign sdo_oe_n         = oe_n_q;
    assign frontend_off     = pd_q | absent;
    assign scan_allowed     = ~frontend_off;
    assign alarm_enable     = feat_q.alarm_en;
    assign result_invalid   = (frontend_off == ALL_OFF)
        || (manual_channel_mode && frontend_off[manual_channel_sel]);
    assign false_alarm_risk = result_invalid && feat_q.alarm_en;

    // ************************************************************
    // Checks
    // ************************************************************
    a_pd_reset : assert property (@(posedge mclk) !nrst |=> (pd_q == POWERDOWN_RESET)
        && (feat_q == FEATURE_RESET))
        else $error("registers not cleared by reset");

    a_all_off_invalid : assert property (@(posedge mclk) disable iff (!nrst)
        (frontend_off == ALL_OFF) |-> result_invalid)
        else $error("all channels off but result valid");

    a_manual_off_alarm : assert property (@(posedge mclk) disable iff (!nrst)
        (manual_channel_mode && frontend_off[manual_channel_sel] && alarm_enable)
        |-> (result_invalid && false_alarm_risk))
        else $error("manual channel off not flagged");

    a_scan_exclude : assert property (@(posedge mclk) disable iff (!nrst)
        $rose(pd_q[0]) |-> (frontend_off[0] && !scan_allowed[0]))
        else $error("powered down channel still scanned");

    a_absent_write : assert property (@(posedge mclk) disable iff (!nrst)
        FOUR_CHAN |=> (pd_q[7:4] == $past(pd_q[7:4])))
        else $error("absent channel bits changed");

    a_absent_read : assert property (@(posedge mclk) disable iff (!nrst)
        (load_read && FOUR_CHAN && (cmd_q[ADDR_HI:ADDR_LO] == ADDR_POWERDOWN))
        |=> (out_q[24:21] == 4'hf))
        else $error("absent channel bits not read as ones");

    a_zero_bits : assert property (@(posedge mclk) disable iff (!nrst)
        $changed(feat_q) |-> (!feat_q.zero5 && !feat_q.zero3))
        else $error("reserved feature bits not zero");

    a_start_edge : assert property (@(posedge mclk) disable iff (!nrst)
        $fell(sdo_oe_n) |-> ((cnt_q == CMD_DONE) && (state_q == FRAME_SHIFT)))
        else $error("output did not start at sixteenth falling edge");

    a_result_place : assert property (@(posedge mclk) disable iff (!nrst)
        load_result |=> (out_q[24:9] == {$past(word.data), RES_PAD}))
        else $error("result not placed in bits 24 to 9");

    a_fmt_low : assert property (@(posedge mclk) disable iff (!nrst)
        (load_result && (feat_q.output_frame_format == FMT_RESULT))
        |=> (out_q[8:0] == TAG_LOW))
        else $error("tag bits not low in result only format");

    a_dev_tag : assert property (@(posedge mclk) disable iff (!nrst)
        (load_result && (feat_q.output_frame_format == FMT_DEV))
        |=> (out_q[4:3] == $past(feat_q.chain_device_id)) && (out_q[2:0] == 3'h0))
        else $error("device tag wrong");

endmodule

// File: verif/spi_host_model.sv
// Host controller model driving the serial link
`timescale 1ns/100ps
module spi_host_model
    import chan_cfg_pkg::*;
(
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe_n
);
    // ****************
    // Frame transfer
    // ****************
    initial begin
        sclk <= 1'b0;
        cs_n <= 1'b1;
        sdi  <= 1'b0;
    end

    task automatic xfer(input logic [15:0] cmd, input bit raw, output logic [24:0] rx,
                        output logic oe_ok);
        logic [15:0] c;
        c = cmd;
        oe_ok = 1'b1;
        if (!raw && c[15:9] == ADDR_FEATURE && c[WR_BIT]) begin
            c[5] = 1'b0;
            c[3] = 1'b0;
        end
        cs_n <= 1'b0;
        #80;
        // Data changes 20 ns before each rising edge, clock period stays 160 ns
        for (int k = 0; k < 40; k++) begin
            sdi <= (k < 16) ? c[15-k] : ~sdi;
            #20 sclk <= 1'b1;
            #80 sclk <= 1'b0;
            #60;
            if (k >= 15) begin
                rx[39-k] = sdo;
                oe_ok &= !sdo_oe_n;
            end
        end
        #20 cs_n <= 1'b1;
        sdi <= ~sdi;
        #80;
    endtask
endmodule

// File: verif/tb_chan_cfg_top.sv
// Self-checking bench for the channel configuration block
`timescale 1ns/100ps
module tb_chan_cfg_top;
    import chan_cfg_pkg::*;

    typedef struct {
        bit          raw;
        logic [7:0]  feat;
        logic [7:0]  rb;
        logic [3:0]  chan;
        logic [13:0] data;
    } row_t;

    logic            mclk, nrst, sclk, cs_n, sdi, sdo, sdo_oe_n, sdo8, oe8, sdo4, oe4, sel4;
    logic            conv_valid, conv_ready, conv_ready4, manual_channel_mode, oe_ok;
    logic            alarm8, alarm4, inv8, inv4, risk8, risk4;
    logic [2:0]      manual_channel_sel;
    logic [7:0]      off8, off4, scan8, scan4;
    logic [24:0]     rx;
    logic [7:0][3:0] chan_range;
    result_word_t    conv_data;
    int              n_mismatch, total_checks, acc;
    row_t            rows[6];

    // Released line shows the inverse of the last bit
    assign sdo      = sel4 ? (oe4 ? !sdo4 : sdo4) : (oe8 ? !sdo8 : sdo8);
    assign sdo_oe_n = sel4 ? oe4 : oe8;

    chan_cfg_top #(.FOUR_CHAN(1'b0)) chan_cfg_top_inst (
        .mclk, .nrst, .sclk, .cs_n, .sdi, .sdo(sdo8), .sdo_oe_n(oe8),
        .conv_valid, .conv_ready, .conv_data, .chan_range, .manual_channel_mode,
        .manual_channel_sel, .frontend_off(off8), .scan_allowed(scan8),
        .alarm_enable(alarm8), .result_invalid(inv8), .false_alarm_risk(risk8)
    );
    chan_cfg_top #(.FOUR_CHAN(1'b1)) chan_cfg_top_inst4 (
        .mclk, .nrst, .sclk, .cs_n, .sdi, .sdo(sdo4), .sdo_oe_n(oe4),
        .conv_valid, .conv_ready(conv_ready4), .conv_data, .chan_range, .manual_channel_mode,
        .manual_channel_sel, .frontend_off(off4), .scan_allowed(scan4),
        .alarm_enable(alarm4), .result_invalid(inv4), .false_alarm_risk(risk4)
    );
    spi_host_model spi_host_model_inst (.sclk, .cs_n, .sdi, .sdo, .sdo_oe_n);

    // ****************
    // Helpers
    // ****************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(string nm, logic [24:0] got, logic [24:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic frame(logic [15:0] cmd, bit raw = 1'b0);
        spi_host_model_inst.xfer(cmd, raw, rx, oe_ok);
    endtask

    task automatic push(result_word_t w);
        @(posedge mclk);
        conv_valid <= 1'b1;
        conv_data  <= w;
        @(posedge mclk);
        conv_valid <= 1'b0;
    endtask

    function automatic logic [24:0] exp_frame(logic [7:0] f, result_word_t w);
        logic [24:0] e;
        e = {w.data, RES_PAD, TAG_LOW};
        if (f[2:0] inside {3'h1, 3'h2, 3'h3}) e[8:5] = w.chan;
        if (f[2:0] inside {3'h2, 3'h3}) e[4:3] = f[7:6];
        if (f[2:0] == 3'h3) e[2:0] = chan_range[w.chan[2:0]][2:0];
        return e;
    endfunction

    initial begin
        #600000;
        n_mismatch++;
        wrap_up();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        nrst = 1'b0;
        sel4 = 1'b0;
        conv_valid = 1'b0;
        conv_data = '0;
        manual_channel_mode = 1'b0;
        manual_channel_sel = 3'h0;
        for (int n = 0; n < 8; n++) chan_range[n] = 4'(14 - n);
        rows = '{'{0, 8'h00, 8'h00, 4'h3, 14'h3fff}, '{0, 8'h41, 8'h41, 4'h5, 14'h2a5a},
                 '{0, 8'h92, 8'h92, 4'h6, 14'h1234}, '{0, 8'hd3, 8'hd3, 4'h7, 14'h0001},
                 '{1, 8'h3b, 8'h13, 4'h0, 14'h2000}, '{0, 8'h06, 8'h06, 4'h4, 14'h0abc}};
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        foreach (rows[i]) begin
            frame({ADDR_FEATURE, 1'b1, rows[i].feat}, rows[i].raw);
            push({rows[i].chan, rows[i].data});
            frame(16'h0000);
            check("frame", rx, exp_frame(rows[i].rb, {rows[i].chan, rows[i].data}));
            check("oe", oe_ok, 1'b1);
            frame({ADDR_FEATURE, 1'b0, 8'h00});
            check("feature", rx, {rows[i].rb, 17'h0});
            check("alarm", alarm8, rows[i].rb[4]);
        end
        $display("row table done");

        frame({ADDR_FEATURE, 1'b1, 8'h10});
        frame({ADDR_POWERDOWN, 1'b1, 8'ha5});
        check("off8", off8, 8'ha5);
        check("scan8", scan8, 8'h5a);
        check("off4", off4, 8'hf5);
        check("scan4", scan4, 8'h0a);
        frame({ADDR_POWERDOWN, 1'b0, 8'h00});
        check("rd8", rx, {8'ha5, 17'h0});
        sel4 = 1'b1;
        frame({ADDR_POWERDOWN, 1'b0, 8'h00});
        check("rd4", rx, {8'hf5, 17'h0});
        sel4 = 1'b0;
        @(posedge mclk);
        manual_channel_mode <= 1'b1;
        @(negedge mclk);
        check("inv", inv8, 1'b1);
        check("risk", risk8, 1'b1);
        @(posedge mclk);
        manual_channel_sel <= 3'h1;
        @(negedge mclk);
        check("inv up", inv8, 1'b0);
        check("risk up", risk8, 1'b0);
        @(posedge mclk);
        manual_channel_mode <= 1'b0;
        frame({ADDR_POWERDOWN, 1'b1, ALL_OFF});
        check("all off", inv8, 1'b1);
        check("no scan", scan8, 8'h00);
        $display("power-down test done");

        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        check("off8 rst", off8, POWERDOWN_RESET);
        check("off4 rst", off4, ABSENT_MASK);
        check("alarm rst", alarm8, 1'b0);
        check("oe rst", oe8, 1'b1);
        repeat (2) @(posedge mclk);
        frame({ADDR_FEATURE, 1'b0, 8'h00});
        check("feat rst", rx, {FEATURE_RESET, 17'h0});
        $display("reset test done");

        acc = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            conv_valid <= 1'b1;
            conv_data  <= {4'(i), 14'(i * 3 + 1)};
            @(negedge mclk);
            acc += int'(conv_ready);
        end
        @(posedge mclk);
        conv_valid <= 1'b0;
        @(negedge mclk);
        check("accepted", 25'(acc), 25'd16);
        check("full", conv_ready, 1'b0);
        for (int i = 0; i < 17; i++) begin
            frame(16'h0000);
            check("drain", rx, {14'((i < 16 ? i : 15) * 3 + 1), 11'h0});
        end
        check("ready", conv_ready, 1'b1);
        $display("buffer test done");
        wrap_up();
    end
endmodule
